//--- shrb_host_model.sv
// Host side model: feeds output FIFO bytes and watches the multi-function IO pin.
module shrb_host_model (
    input  wire logic       i_clock,
    input  wire logic       i_arst_n,
    input  wire logic [7:0] i_count,
    input  wire logic       i_ready,
    input  wire logic       i_pin_n,
    output logic            o_valid,
    output logic [7:0]      o_byte,
    output logic            o_seen
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] sent_q;

    // Between bytes the data lines show the inverse of the next value to send.
    assign o_valid = sent_q < i_count;
    assign o_byte  = o_valid ? sent_q : ~sent_q;

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sent_q <= 8'h00;
            o_seen <= 1'b0;
        end else begin
            if (o_valid && i_ready) begin
                sent_q <= sent_q + 8'h01;
            end
            if (!i_pin_n) begin
                o_seen <= 1'b1;
            end
        end
    end
endmodule

//--- shrb_out_fifo.sv
// Output sample FIFO with a read pointer that advances per byte and a count of whole samples.
module shrb_out_fifo #(
    parameter int DEPTH        = 64,
    parameter int SAMPLE_BYTES = 6
) (
    input  wire logic       i_clock,
    input  wire logic       i_arst_n,
    input  wire logic       i_push,
    input  wire logic [7:0] i_wdata,
    output logic            o_full,
    input  wire logic       i_pop,
    output logic [7:0]      o_rdata,
    output logic            o_empty,
    output logic [7:0]      o_samples
);
    localparam int AW = $clog2(DEPTH);
    localparam int PW = $clog2(SAMPLE_BYTES + 1);
    localparam logic [PW-1:0] LAST = PW'(SAMPLE_BYTES - 1);
    localparam logic [AW:0]   FULL = (AW + 1)'(DEPTH);

    logic [7:0]    mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0]   bytes_q;
    logic [PW-1:0] wr_phase_q;
    logic [PW-1:0] rd_phase_q;
    logic [7:0]    samples_q;
    logic          do_push;
    logic          do_pop;
    logic          wr_done;
    logic          rd_done;

    assign o_full    = bytes_q == FULL;
    assign o_empty   = bytes_q == '0;
    assign do_push   = i_push && !o_full;
    assign do_pop    = i_pop && !o_empty;
    assign wr_done   = do_push && wr_phase_q == LAST;
    assign rd_done   = do_pop && rd_phase_q == LAST;
    assign o_rdata   = mem_q[rd_ptr_q];
    assign o_samples = samples_q;

    always_ff @(posedge i_clock) begin
        if (do_push) begin
            mem_q[wr_ptr_q] <= i_wdata;
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wr_ptr_q   <= '0;
            rd_ptr_q   <= '0;
            bytes_q    <= '0;
            wr_phase_q <= '0;
            rd_phase_q <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_q   <= AW'(wr_ptr_q + 1'b1);
                wr_phase_q <= wr_done ? '0 : PW'(wr_phase_q + 1'b1);
            end
            if (do_pop) begin
                rd_ptr_q   <= AW'(rd_ptr_q + 1'b1);
                rd_phase_q <= rd_done ? '0 : PW'(rd_phase_q + 1'b1);
            end
            bytes_q <= (AW + 1)'(bytes_q + do_push - do_pop);
        end
    end

    // A sample leaves the count only once all its bytes were read.
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            samples_q <= '0;
        end else begin
            samples_q <= 8'(samples_q + wr_done - rd_done);
        end
    end

    a_sample_hold : assert property (
        @(posedge i_clock) disable iff (!i_arst_n)
        (do_pop && rd_phase_q != LAST && !wr_done) |=> $stable(samples_q))
        else $error("sample count moved before a whole sample was read");

endmodule

//--- shrb_pkg.sv
// Shared constants and types of the sensor hub read-back command block.
package shrb_pkg;

    // Register port byte addresses.
    localparam logic [7:0] SHRB_ADDR_CMD       = 8'h00;
    localparam logic [7:0] SHRB_ADDR_RESP      = 8'h04;
    localparam logic [7:0] SHRB_ADDR_RESP_LEFT = 8'h08;
    localparam logic [7:0] SHRB_ADDR_STATUS    = 8'h0c;
    localparam logic [7:0] SHRB_ADDR_IRQ_STAT  = 8'h10;
    localparam logic [7:0] SHRB_ADDR_IRQ_MASK  = 8'h14;

    // Bit positions.
    localparam int SHRB_STATUS_RDY_BIT = 3;
    localparam int SHRB_IRQ_RDY_BIT    = 0;
    localparam int SHRB_IRQ_BAD_BIT    = 1;
    localparam int SHRB_IRQ_BITS       = 2;

    // Command families, indices and selectors.
    localparam logic [7:0] SHRB_FAM_SET    = 8'h10;
    localparam logic [7:0] SHRB_FAM_GET    = 8'h11;
    localparam logic [7:0] SHRB_FAM_OFIFO  = 8'h12;
    localparam logic [7:0] SHRB_FAM_INFIFO = 8'h13;
    localparam logic [7:0] SHRB_IDX_0      = 8'h00;
    localparam logic [7:0] SHRB_IDX_1      = 8'h01;
    localparam logic [7:0] SHRB_IDX_2      = 8'h02;
    localparam logic [7:0] SHRB_IDX_3      = 8'h03;
    localparam logic [7:0] SHRB_IDX_4      = 8'h04;
    localparam logic [7:0] SHRB_SEL_ACCEL  = 8'h04;

    // Output format codes.
    localparam logic [7:0] SHRB_FMT_PAUSE  = 8'h00;
    localparam logic [7:0] SHRB_FMT_PAUSE2 = 8'h04;
    localparam logic [7:0] SHRB_FMT_MAX    = 8'h07;
    localparam logic [7:0] SHRB_FMT_CNT_0  = 8'h05;
    localparam logic [7:0] SHRB_FMT_SENSOR = 8'h01;
    localparam logic [7:0] SHRB_FMT_ALGO   = 8'h02;

    // External accelerometer sample: three signed 16-bit axes, 0.001 g LSB.
    localparam int         SHRB_ACC_AXES       = 3;
    localparam int         SHRB_ACC_AXIS_BYTES = 2;
    localparam logic [7:0] SHRB_ACC_SAMPLE_BYTES =
        8'(SHRB_ACC_AXES * SHRB_ACC_AXIS_BYTES);

    // Reset values.
    localparam logic [7:0] SHRB_FMT_RESET     = 8'h00;
    localparam logic [7:0] SHRB_THRESH_RESET  = 8'h01;
    localparam logic [7:0] SHRB_PERIOD_RESET  = 8'h01;
    localparam logic [7:0] SHRB_COUNTER_RESET = 8'h00;
    localparam logic [7:0] SHRB_MASK_RESET    = 8'h00;

    // Sample timing.
    localparam int SHRB_CLOCK_HZ      = 50_000_000;
    localparam int SHRB_SAMPLE_MS     = 40;
    localparam int SHRB_SAMPLE_CYCLES = SHRB_SAMPLE_MS * (SHRB_CLOCK_HZ / 1000);

    typedef enum logic [1:0] {
        SHRB_ST_FAMILY = 2'b00,
        SHRB_ST_INDEX  = 2'b01,
        SHRB_ST_ARG    = 2'b10
    } shrb_state_t;

endpackage

//--- shrb_top.sv
// Sensor hub read-back command interpreter with output FIFO and interrupt.
//
// Summary of operation
// - Family 11 index 00 returns output format.
// - Format codes: pause, sensor, algo, counter-prefixed.
// - Family 11 index 01 returns FIFO threshold.
// - Threshold reached sets ready flag and pin.
// - Family 11 index 02 returns report period.
// - Family 11 index 03 returns bus address.
// - Family 11 index 04 returns hub counter.
// - Family 12 index 00 returns sample count.
// - Family 12 index 01 streams, pointer per byte.
// - Accelerometer selector returns sample size six.
// - Accelerometer sample: three signed 16-bit axes.
// - Family 13 indices 01-03 return 16-bit MSB-first.
// - Input FIFO queries only with external accelerometer.
// - Family 10 index 00 writes output format.
// - Status bit 3 shows FIFO at threshold.
//
// Our own choices: the plain strobed port and the placing of the registers.
module shrb_top
    import shrb_pkg::*;
#(
    parameter int         OUT_DEPTH     = 64,
    parameter int         SAMPLE_BYTES  = 6,
    parameter logic [15:0] IN_FIFO_CAP  = 16'h0040,
    parameter logic [15:0] SENS_FIFO_CAP = 16'h0040,
    parameter logic [7:0] BUS_ADDR_RESET = 8'h55,
    parameter int         SAMPLE_CYCLES = shrb_pkg::SHRB_SAMPLE_CYCLES
) (
    input  wire logic        i_clock,
    input  wire logic        i_arst_n,
    input  wire logic [7:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic [31:0]      o_rdata,
    input  wire logic        i_out_valid,
    input  wire logic [7:0]  i_out_byte,
    output logic             o_out_ready,
    input  wire logic        i_ext_accel,
    input  wire logic [15:0] i_in_fill,
    output logic             o_multi_function_io_pin_n,
    output logic             o_report,
    output logic             o_irq
);
    import shrb_pkg::*;

    function automatic logic needs_arg(input logic [7:0] fam,
                                       input logic [7:0] idx);
        needs_arg = fam == SHRB_FAM_SET ||
                    (fam == SHRB_FAM_INFIFO && idx != SHRB_IDX_1);
    endfunction

    // Paused formats produce no reports at all.
    function automatic logic fmt_paused(input logic [7:0] fmt);
        fmt_paused = fmt == SHRB_FMT_PAUSE || fmt == SHRB_FMT_PAUSE2;
    endfunction

    shrb_state_t state_q;
    logic [7:0]  fam_q;
    logic [7:0]  idx_q;
    logic [7:0]  fmt_q;
    logic [7:0]  thresh_q;
    logic [7:0]  period_q;
    logic [7:0]  bus_addr_q;
    logic [7:0]  counter_q;
    logic [15:0] resp_q;
    logic [1:0]  resp_left_q;
    logic        stream_q;
    logic        data_ready_q;
    logic [SHRB_IRQ_BITS-1:0] irq_stat_q;
    logic [SHRB_IRQ_BITS-1:0] irq_mask_q;
    logic [31:0] rdata_q;
    logic        irq_q;
    logic        pin_n_q;
    logic        report_q;
    logic        ready_q;
    logic [31:0] timer_q;
    logic [7:0]  report_cnt_q;

    logic        cmd_wr;
    logic [7:0]  cmd_byte;
    logic        exec;
    logic [7:0]  exec_idx;
    logic        known;
    logic [15:0] rval;
    logic [1:0]  rlen;
    logic        rstream;
    logic        resp_rd;
    logic        fifo_pop;
    logic [7:0]  fifo_byte;
    logic        fifo_empty;
    logic        fifo_full;
    logic [7:0]  samples;
    logic        ready_now;
    logic        rdy_event;
    logic        bad_event;
    logic        stat_rd;
    logic        tick;

    assign cmd_wr   = i_wr && i_addr == SHRB_ADDR_CMD;
    assign cmd_byte = i_wdata[7:0];
    assign exec_idx = (state_q == SHRB_ST_INDEX) ? cmd_byte : idx_q;
    assign exec     = cmd_wr && ((state_q == SHRB_ST_INDEX &&
                      !needs_arg(fam_q, cmd_byte)) || state_q == SHRB_ST_ARG);

    // Command byte sequencer: family, index, then optional argument.
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_q <= SHRB_ST_FAMILY;
            fam_q   <= '0;
            idx_q   <= '0;
        end else if (cmd_wr) begin
            unique case (state_q)
                SHRB_ST_FAMILY: begin
                    fam_q   <= cmd_byte;
                    state_q <= SHRB_ST_INDEX;
                end
                SHRB_ST_INDEX: begin
                    idx_q   <= cmd_byte;
                    state_q <= needs_arg(fam_q, cmd_byte) ? SHRB_ST_ARG
                                                          : SHRB_ST_FAMILY;
                end
                SHRB_ST_ARG: begin
                    state_q <= SHRB_ST_FAMILY;
                end
                default: begin
                    state_q <= SHRB_ST_FAMILY;
                end
            endcase
        end
    end

    // Decode of a complete command into its answer.
    always_comb begin
        known   = 1'b0;
        rval    = '0;
        rlen    = 2'd0;
        rstream = 1'b0;
        unique case (fam_q)
            SHRB_FAM_SET: begin
                unique case (exec_idx)
                    SHRB_IDX_0: known = cmd_byte <= SHRB_FMT_MAX;
                    SHRB_IDX_1: known = cmd_byte != 8'h00;
                    SHRB_IDX_2: known = cmd_byte != 8'h00;
                    SHRB_IDX_3: known = 1'b1;
                    SHRB_IDX_4: known = 1'b1;
                    default:    known = 1'b0;
                endcase
            end
            SHRB_FAM_GET: begin
                known = 1'b1;
                rlen  = 2'd1;
                unique case (exec_idx)
                    SHRB_IDX_0: rval = {fmt_q, 8'h00};
                    SHRB_IDX_1: rval = {thresh_q, 8'h00};
                    SHRB_IDX_2: rval = {period_q, 8'h00};
                    SHRB_IDX_3: rval = {bus_addr_q, 8'h00};
                    SHRB_IDX_4: rval = {counter_q, 8'h00};
                    default: begin
                        known = 1'b0;
                        rlen  = 2'd0;
                    end
                endcase
            end
            SHRB_FAM_OFIFO: begin
                if (exec_idx == SHRB_IDX_0) begin
                    known = 1'b1;
                    rlen  = 2'd1;
                    rval  = {samples, 8'h00};
                end else if (exec_idx == SHRB_IDX_1) begin
                    known   = 1'b1;
                    rstream = 1'b1;
                end
            end
            SHRB_FAM_INFIFO: begin
                // Without an external accelerometer these stay unknown.
                if (i_ext_accel) begin
                    if (exec_idx == SHRB_IDX_1) begin
                        known = 1'b1;
                        rlen  = 2'd2;
                        rval  = IN_FIFO_CAP;
                    end else if (cmd_byte == SHRB_SEL_ACCEL) begin
                        known = 1'b1;
                        unique case (exec_idx)
                            SHRB_IDX_0: begin
                                rlen = 2'd1;
                                rval = {SHRB_ACC_SAMPLE_BYTES, 8'h00};
                            end
                            SHRB_IDX_2: begin
                                rlen = 2'd2;
                                rval = SENS_FIFO_CAP;
                            end
                            SHRB_IDX_3: begin
                                rlen = 2'd2;
                                rval = i_in_fill;
                            end
                            default: known = 1'b0;
                        endcase
                    end
                end
            end
            default: known = 1'b0;
        endcase
    end

    // Configuration is only written by a valid set command.
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            fmt_q      <= SHRB_FMT_RESET;
            thresh_q   <= SHRB_THRESH_RESET;
            period_q   <= SHRB_PERIOD_RESET;
            bus_addr_q <= BUS_ADDR_RESET;
        end else if (exec && known && fam_q == SHRB_FAM_SET) begin
            unique case (exec_idx)
                SHRB_IDX_0: fmt_q      <= cmd_byte;
                SHRB_IDX_1: thresh_q   <= cmd_byte;
                SHRB_IDX_2: period_q   <= cmd_byte;
                SHRB_IDX_3: bus_addr_q <= cmd_byte;
                default: ;
            endcase
        end
    end

    // Answer buffer; a new command discards any unread answer.
    assign resp_rd  = i_rd && i_addr == SHRB_ADDR_RESP;
    assign fifo_pop = resp_rd && stream_q;

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            resp_q      <= '0;
            resp_left_q <= 2'd0;
            stream_q    <= 1'b0;
        end else if (exec) begin
            resp_q      <= known ? rval : 16'h0000;
            resp_left_q <= known ? rlen : 2'd0;
            stream_q    <= known && rstream;
        end else if (cmd_wr) begin
            resp_left_q <= 2'd0;
            stream_q    <= 1'b0;
        end else if (resp_rd && resp_left_q != 2'd0) begin
            resp_q      <= {resp_q[7:0], 8'h00};
            resp_left_q <= 2'(resp_left_q - 1'b1);
        end
    end

    // Data-ready level and its interrupt events.
    assign ready_now = samples >= thresh_q;
    assign rdy_event = ready_now && !data_ready_q;
    assign bad_event = exec && !known;
    assign stat_rd   = i_rd && i_addr == SHRB_ADDR_IRQ_STAT;

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            data_ready_q <= 1'b0;
            pin_n_q      <= 1'b1;
        end else begin
            data_ready_q <= ready_now;
            pin_n_q      <= !ready_now;
        end
    end

    // An event in the same cycle as the clearing read is kept.
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            irq_stat_q <= '0;
        end else begin
            irq_stat_q <= (stat_rd ? '0 : irq_stat_q) |
                          {bad_event, rdy_event};
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            irq_mask_q <= SHRB_MASK_RESET[SHRB_IRQ_BITS-1:0];
            irq_q      <= 1'b0;
        end else begin
            if (i_wr && i_addr == SHRB_ADDR_IRQ_MASK) begin
                irq_mask_q <= i_wdata[SHRB_IRQ_BITS-1:0];
            end
            irq_q <= |(irq_stat_q & irq_mask_q);
        end
    end

    // Sample timer drives the hub counter and the report period.
    assign tick = timer_q == 32'(SAMPLE_CYCLES - 1);

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            timer_q      <= '0;
            counter_q    <= SHRB_COUNTER_RESET;
            report_cnt_q <= 8'h00;
            report_q     <= 1'b0;
        end else begin
            timer_q  <= tick ? '0 : 32'(timer_q + 1'b1);
            report_q <= 1'b0;
            if (exec && known && fam_q == SHRB_FAM_SET &&
                exec_idx == SHRB_IDX_4) begin
                counter_q <= cmd_byte;
            end else if (tick) begin
                counter_q <= 8'(counter_q + 1'b1);
            end
            if (tick) begin
                if (report_cnt_q + 8'h01 >= period_q) begin
                    report_cnt_q <= 8'h00;
                    report_q     <= !fmt_paused(fmt_q);
                end else begin
                    report_cnt_q <= 8'(report_cnt_q + 1'b1);
                end
            end
        end
    end

    // Read data stands only in the cycle after the read strobe.
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= '0;
            if (i_rd) begin
                unique case (i_addr)
                    SHRB_ADDR_RESP: begin
                        if (stream_q) begin
                            rdata_q <= {24'h0, fifo_empty ? 8'h00 : fifo_byte};
                        end else if (resp_left_q != 2'd0) begin
                            rdata_q <= {24'h0, resp_q[15:8]};
                        end
                    end
                    SHRB_ADDR_RESP_LEFT: rdata_q <= {30'h0, resp_left_q};
                    SHRB_ADDR_STATUS:
                        rdata_q[SHRB_STATUS_RDY_BIT] <= data_ready_q;
                    SHRB_ADDR_IRQ_STAT:
                        rdata_q[SHRB_IRQ_BITS-1:0] <= irq_stat_q;
                    SHRB_ADDR_IRQ_MASK:
                        rdata_q[SHRB_IRQ_BITS-1:0] <= irq_mask_q;
                    default: rdata_q <= '0;
                endcase
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ready_q <= 1'b0;
        end else begin
            ready_q <= !fifo_full;
        end
    end

    assign o_rdata                   = rdata_q;
    assign o_irq                     = irq_q;
    assign o_multi_function_io_pin_n = pin_n_q;
    assign o_report                  = report_q;
    assign o_out_ready               = ready_q;

    // Ready is one cycle late, so a byte offered while full is dropped.
    shrb_out_fifo #(
        .DEPTH        (OUT_DEPTH),
        .SAMPLE_BYTES (SAMPLE_BYTES)
    ) u_out_fifo (
        .i_clock   (i_clock),
        .i_arst_n  (i_arst_n),
        .i_push    (i_out_valid && ready_q),
        .i_wdata   (i_out_byte),
        .o_full    (fifo_full),
        .i_pop     (fifo_pop),
        .o_rdata   (fifo_byte),
        .o_empty   (fifo_empty),
        .o_samples (samples)
    );

    a_fmt_readback : assert property (
        @(posedge i_clock) disable iff (!i_arst_n)
        (exec && fam_q == SHRB_FAM_GET && exec_idx == SHRB_IDX_0)
        |=> resp_left_q == 2'd1 && resp_q[15:8] == $past(fmt_q))
        else $error("format read-back wrong");
    a_thresh_range : assert property (
        @(posedge i_clock) disable iff (!i_arst_n) thresh_q != 8'h00)
        else $error("threshold left its range");
    a_period_range : assert property (
        @(posedge i_clock) disable iff (!i_arst_n) period_q != 8'h00)
        else $error("report period left its range");
    a_ready_flag : assert property (
        @(posedge i_clock) disable iff (!i_arst_n)
        ##1 data_ready_q == ($past(samples) >= $past(thresh_q)))
        else $error("ready flag does not follow FIFO level");
    a_ready_irq : assert property (
        @(posedge i_clock) disable iff (!i_arst_n)
        $rose(data_ready_q) |-> irq_stat_q[SHRB_IRQ_RDY_BIT] && !pin_n_q)
        else $error("threshold event not flagged");
    a_bad_cmd : assert property (
        @(posedge i_clock) disable iff (!i_arst_n)
        (exec && !known) |=> resp_left_q == 2'd0 && !stream_q &&
        $stable(fmt_q) && $stable(thresh_q) && $stable(period_q))
        else $error("unknown command had an effect");
    a_fill_order : assert property (
        @(posedge i_clock) disable iff (!i_arst_n)
        (exec && known && fam_q == SHRB_FAM_INFIFO && exec_idx == SHRB_IDX_3)
        |=> resp_left_q == 2'd2 && resp_q == $past(i_in_fill))
        else $error("input fill not answered MSB first");
    a_ext_only : assert property (
        @(posedge i_clock) disable iff (!i_arst_n)
        (exec && fam_q == SHRB_FAM_INFIFO && !i_ext_accel)
        |=> resp_left_q == 2'd0)
        else $error("input FIFO query answered without external sensor");
    a_size_six : assert property (
        @(posedge i_clock) disable iff (!i_arst_n)
        (exec && known && fam_q == SHRB_FAM_INFIFO && exec_idx == SHRB_IDX_0)
        |=> resp_q[15:8] == 8'h06)
        else $error("accelerometer sample size wrong");

endmodule

//--- test_shrb_top.sv
// Self-checking bench of the sensor hub read-back command block.
module test_shrb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import shrb_pkg::*;
    localparam logic [15:0] CAP = 16'h0203;
    localparam logic [15:0] SCAP = 16'h0405;
    localparam logic [7:0]  BADDR = 8'h3a;
    logic        i_clock = 0, i_arst_n = 0, i_wr = 0, i_rd = 0;
    logic        i_ext_accel = 1, ov, rdy, pin_n, rep, irq, seen;
    logic [7:0]  i_addr = 0, npush = 0, ob, v;
    logic [31:0] i_wdata = 0, o_rdata;
    logic [15:0] i_in_fill = 16'h0123;
    int          n_mismatch = 0, n_compared = 0;

    shrb_top #(.IN_FIFO_CAP(CAP), .SENS_FIFO_CAP(SCAP),
        .BUS_ADDR_RESET(BADDR), .SAMPLE_CYCLES(20)) shrb_top_inst (
        .i_clock(i_clock), .i_arst_n(i_arst_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_out_valid(ov), .i_out_byte(ob), .o_out_ready(rdy),
        .i_ext_accel(i_ext_accel), .i_in_fill(i_in_fill),
        .o_multi_function_io_pin_n(pin_n), .o_report(rep), .o_irq(irq));
    shrb_host_model shrb_host_model_inst (
        .i_clock(i_clock), .i_arst_n(i_arst_n), .i_count(npush),
        .i_ready(rdy), .i_pin_n(pin_n), .o_valid(ov), .o_byte(ob),
        .o_seen(seen));

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clock);
        i_wr <= 1'b1; i_addr <= a; i_wdata <= {24'h0, d};
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge i_clock);
        i_rd <= 1'b1; i_addr <= a;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1 v = o_rdata[7:0];
    endtask
    task chk(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h want %h", $time, g, e);
        end
    endtask
    task cmd(input logic [7:0] f, input logic [7:0] i);
        wr(SHRB_ADDR_CMD, f);
        wr(SHRB_ADDR_CMD, i);
    endtask
    task ask(input logic [7:0] f, input logic [7:0] i, input logic [7:0] e);
        cmd(f, i);
        rd(SHRB_ADDR_RESP);
        chk(v, e);
    endtask
    task report_and_stop;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task t_defaults;
        ask(SHRB_FAM_GET, SHRB_IDX_0, SHRB_FMT_RESET);
        ask(SHRB_FAM_GET, SHRB_IDX_1, SHRB_THRESH_RESET);
        ask(SHRB_FAM_GET, SHRB_IDX_2, SHRB_PERIOD_RESET);
        ask(SHRB_FAM_GET, SHRB_IDX_3, BADDR);
    endtask
    task t_formats;
        for (int k = 0; k < 8; k++) begin
            cmd(SHRB_FAM_SET, SHRB_IDX_0);
            wr(SHRB_ADDR_CMD, 8'(k));
            ask(SHRB_FAM_GET, SHRB_IDX_0, 8'(k));
        end
        cmd(SHRB_FAM_SET, SHRB_IDX_0);
        wr(SHRB_ADDR_CMD, 8'h08);
        ask(SHRB_FAM_GET, SHRB_IDX_0, 8'h07);
        rd(SHRB_ADDR_IRQ_STAT);
        chk(8'(v[1]), 8'h01);
    endtask
    task t_config;
        int n;
        cmd(SHRB_FAM_SET, SHRB_IDX_3);
        wr(SHRB_ADDR_CMD, 8'ha7);
        ask(SHRB_FAM_GET, SHRB_IDX_3, 8'ha7);
        cmd(SHRB_FAM_SET, SHRB_IDX_1);
        wr(SHRB_ADDR_CMD, 8'h00);
        ask(SHRB_FAM_GET, SHRB_IDX_1, SHRB_THRESH_RESET);
        cmd(SHRB_FAM_SET, SHRB_IDX_2);
        wr(SHRB_ADDR_CMD, 8'h00);
        ask(SHRB_FAM_GET, SHRB_IDX_2, SHRB_PERIOD_RESET);
        // Start just after a report, so no sample tick lands before the read.
        @(posedge i_clock iff rep);
        cmd(SHRB_FAM_SET, SHRB_IDX_4);
        wr(SHRB_ADDR_CMD, 8'h3c);
        ask(SHRB_FAM_GET, SHRB_IDX_4, 8'h3c);
        // Period two, then a paused format; a pulse in flight is skipped.
        for (int k = 0; k < 2; k++) begin
            cmd(SHRB_FAM_SET, k == 0 ? SHRB_IDX_2 : SHRB_IDX_0);
            wr(SHRB_ADDR_CMD, k == 0 ? 8'h02 : SHRB_FMT_PAUSE2);
            n = 0;
            @(posedge i_clock);
            repeat (80) @(posedge i_clock) n += rep;
            chk(8'(n), k == 0 ? 8'h02 : 8'h00);
        end
    endtask
    task t_fifo;
        cmd(SHRB_FAM_SET, SHRB_IDX_1);
        wr(SHRB_ADDR_CMD, 8'h02);
        wr(SHRB_ADDR_IRQ_MASK, 8'h01);
        npush <= 8'd12;
        repeat (20) @(posedge i_clock);
        chk(8'(pin_n), 8'h00);
        chk(8'(irq), 8'h01);
        rd(SHRB_ADDR_STATUS);
        chk(8'(v[3]), 8'h01);
        ask(SHRB_FAM_OFIFO, SHRB_IDX_0, 8'h02);
        cmd(SHRB_FAM_OFIFO, SHRB_IDX_1);
        for (int k = 0; k < 6; k++) begin
            rd(SHRB_ADDR_RESP);
            chk(v, 8'(k));
        end
        ask(SHRB_FAM_OFIFO, SHRB_IDX_0, 8'h01);
        rd(SHRB_ADDR_IRQ_STAT);
        chk(8'(v[0]), 8'h01);
        rd(SHRB_ADDR_STATUS);
        chk(8'(v[3]), 8'h00);
        chk(8'(irq), 8'h00);
        chk(8'(pin_n), 8'h01);
        chk(8'(seen), 8'h01);
    endtask
    task t_infifo;
        cmd(SHRB_FAM_INFIFO, SHRB_IDX_0);
        wr(SHRB_ADDR_CMD, SHRB_SEL_ACCEL);
        rd(SHRB_ADDR_RESP);
        chk(v, 8'h06);
        cmd(SHRB_FAM_INFIFO, SHRB_IDX_1);
        rd(SHRB_ADDR_RESP);
        chk(v, CAP[15:8]);
        rd(SHRB_ADDR_RESP);
        chk(v, CAP[7:0]);
        cmd(SHRB_FAM_INFIFO, SHRB_IDX_2);
        wr(SHRB_ADDR_CMD, SHRB_SEL_ACCEL);
        rd(SHRB_ADDR_RESP);
        chk(v, SCAP[15:8]);
        rd(SHRB_ADDR_RESP);
        chk(v, SCAP[7:0]);
        cmd(SHRB_FAM_INFIFO, SHRB_IDX_3);
        wr(SHRB_ADDR_CMD, SHRB_SEL_ACCEL);
        rd(SHRB_ADDR_RESP);
        chk(v, i_in_fill[15:8]);
        rd(SHRB_ADDR_RESP);
        chk(v, i_in_fill[7:0]);
        @(posedge i_clock) i_ext_accel <= 1'b0;
        cmd(SHRB_FAM_INFIFO, SHRB_IDX_1);
        rd(SHRB_ADDR_RESP_LEFT);
        chk(v, 8'h00);
    endtask

    initial begin
        forever #10 i_clock = ~i_clock;
    end
    initial begin
        #50us;
        n_mismatch++;
        report_and_stop;
    end
    initial begin
        repeat (8) @(posedge i_clock);
        i_arst_n <= 1'b1;
        t_defaults;
        t_formats;
        t_config;
        t_fifo;
        t_infifo;
        report_and_stop;
    end
endmodule
